// ===== rtl/ihd_map.vh
// Addresses, field positions, reset values and timing of the host/DAC pin block
`ifndef IHD_MAP_VH
`define IHD_MAP_VH
// I/O addresses
`define IHD_AUX_BASE 16'h02d0
`define IHD_OFF_SENSE 16'h0008
`define IHD_OFF_CTL 16'h000b
`define IHD_OFF_STRAP 16'h000c
`define IHD_MISC_ADDR 16'h03c2
`define IHD_DAC_LO 16'h03c6
`define IHD_DAC_HI 16'h03c9
// Display memory window
`define IHD_MEM_LO 24'h0a_0000
`define IHD_MEM_HI 24'h0b_ffff
// I/O select codes
`define IHD_SEL_NONE 3'h0
`define IHD_SEL_SENSE 3'h1
`define IHD_SEL_CTL 3'h2
`define IHD_SEL_STRAP 3'h3
`define IHD_SEL_MISC 3'h4
`define IHD_SEL_DAC 3'h5
// dac_pin_control fields
`define IHD_CTL_RS_HI 3
`define IHD_CTL_MODE 4
`define IHD_CTL_PANEL_FLOAT 6
`define IHD_CTL_IRQ_DIS 7
`define IHD_CTL_RST 8'h00
// misc_output_control fields
`define IHD_MISC_HPOL 6
`define IHD_MISC_VPOL 7
`define IHD_MISC_RST 8'h00
// Strap positions on the memory data pins
`define IHD_STRAP_ALE 5
`define IHD_STRAP_OVL 13
`define IHD_STRAP_SLOW 14
`define IHD_STRAP_LO_MSB 3
`define IHD_STRAP_LO_LSB 0
`define IHD_STRAP_HI_MSB 12
`define IHD_STRAP_HI_LSB 9
`define IHD_STRAP_RST 8'h00
// Synchroniser reset: strobes, enables, suspend and sense pins at idle level
`define IHD_PIN_IDLE 69'h00_0000_0000_1f77_0000
// Address bits latched on ALE
`define IHD_LAT_MSB 23
`define IHD_LAT_LSB 2
// Timing
`define IHD_CLK_NS 20
`define IHD_MEM_WAIT_NS 100
`define IHD_MEM_WAIT_CYC ((`IHD_MEM_WAIT_NS + `IHD_CLK_NS - 1) / `IHD_CLK_NS)
`define IHD_CNT_ONE 3'h1
`endif

// ===== rtl/ihd_top.v
// Host ISA slave port, suspend, strap capture and palette DAC pins
`timescale 1ns/1ns
`include "ihd_map.vh"
module ihd_top (
  // Clock, reset, enable
  input wire clk_sys_i,
  input wire reset_n_i,
  input wire ce_i,
  // ISA pins
  input wire [23:0] isa_addr_i,
  input wire [15:0] isa_data_i,
  output reg [15:0] isa_data_o,
  output reg isa_data_oe_o,
  input wire isa_ior_n_i,
  input wire isa_iow_n_i,
  input wire isa_memr_n_i,
  input wire isa_memw_n_i,
  input wire isa_bhe_n_i,
  input wire isa_ale_i,
  input wire memory_decode_enable_i,
  input wire io_decode_enable_n_i,
  input wire isa_reset_i,
  output reg isa_ready_o,
  output reg isa_ready_oe_o,
  output reg isa_irq_o,
  output reg isa_irq_oe_o,
  output reg isa_zws_n_o,
  output reg isa_zws_oe_o,
  // Power and strap pins
  input wire hw_suspend_request_n_i,
  input wire [15:0] memory_data_pins_i,
  output reg power_down_o,
  output reg internal_slow_clock_enable_o,
  // Display memory side
  input wire [15:0] host_mem_rdata_i,
  output reg [23:0] host_addr_o,
  output reg host_mem_req_o,
  output reg host_mem_write_o,
  output reg [15:0] host_wdata_o,
  output reg host_bhe_n_o,
  // Display timing unit side
  input wire [7:0] dtu_pixel_i,
  input wire dtu_blank_i,
  input wire dtu_hsync_i,
  input wire dtu_vsync_i,
  input wire dtu_vretrace_i,
  input wire dtu_irq_enable_i,
  input wire dtu_irq_clear_i,
  input wire dtu_running_i,
  input wire seq_reset_i,
  input wire sw_power_save_i,
  input wire [2:0] cursor_overlay_i,
  input wire [7:0] panel_data_i,
  input wire panel_shift_clock_i,
  input wire backplane_bias_i,
  // Palette DAC pins
  output reg [7:0] pixel_select_out_o,
  output reg dac_pixel_clock_o,
  output reg dac_blank_n_o,
  output reg dac_hsync_o,
  output reg dac_vsync_o,
  output reg dac_read_strobe_n_o,
  output reg dac_write_strobe_n_o,
  output reg dac_register_select_hi_o,
  output reg dac_mode_control_o,
  output reg [1:0] overlay_select_low_o,
  output reg overlay_select_low_oe_o,
  output reg overlay_select_upper_o,
  input wire [2:0] monitor_sense_in_i,
  // Panel pins
  output reg [3:0] upper_panel_data_o,
  output reg [3:0] lower_panel_data_o,
  output reg panel_shift_clock_o,
  output reg backplane_bias_o,
  output reg panel_oe_o,
  output reg panel_power_enable_n_o
);

  localparam ST_IDLE = 2'b00;
  localparam ST_WAIT = 2'b01;
  localparam ST_DONE = 2'b10;

  function [2:0] io_sel;
    input [15:0] a;
    begin
      if (a == `IHD_AUX_BASE + `IHD_OFF_SENSE)
        io_sel = `IHD_SEL_SENSE;
      else if (a == `IHD_AUX_BASE + `IHD_OFF_CTL)
        io_sel = `IHD_SEL_CTL;
      else if (a == `IHD_AUX_BASE + `IHD_OFF_STRAP)
        io_sel = `IHD_SEL_STRAP;
      else if (a == `IHD_MISC_ADDR)
        io_sel = `IHD_SEL_MISC;
      else if (a >= `IHD_DAC_LO && a <= `IHD_DAC_HI)
        io_sel = `IHD_SEL_DAC;
      else
        io_sel = `IHD_SEL_NONE;
    end
  endfunction

  // Two-stage synchroniser for every pin input
  wire [68:0] pin_raw;
  reg [68:0] pin_s1_r;
  reg [68:0] pin_s2_r;
  assign pin_raw = {isa_addr_i, isa_data_i, isa_ior_n_i, isa_iow_n_i,
    isa_memr_n_i, isa_memw_n_i, isa_bhe_n_i, isa_ale_i,
    memory_decode_enable_i, io_decode_enable_n_i, hw_suspend_request_n_i,
    isa_reset_i, monitor_sense_in_i, memory_data_pins_i};

  always @(posedge clk_sys_i or negedge reset_n_i)
  begin
    if (!reset_n_i)
    begin
      pin_s1_r <= `IHD_PIN_IDLE;
      pin_s2_r <= `IHD_PIN_IDLE;
    end
    else if (ce_i)
    begin
      pin_s1_r <= pin_raw;
      pin_s2_r <= pin_s1_r;
    end
  end

  wire [23:0] addr_s;
  wire [15:0] data_s;
  wire ior_n_s;
  wire iow_n_s;
  wire memr_n_s;
  wire memw_n_s;
  wire bhe_n_s;
  wire ale_s;
  wire memory_decode_enable_s;
  wire io_decode_enable_n_n_s;
  wire susp_n_s;
  wire rst_pin_s;
  wire [2:0] sense_s;
  wire [15:0] md_s;
  assign {addr_s, data_s, ior_n_s, iow_n_s, memr_n_s, memw_n_s, bhe_n_s,
    ale_s, memory_decode_enable_s, io_decode_enable_n_n_s, susp_n_s, rst_pin_s, sense_s, md_s} = pin_s2_r;

  reg [7:0] ctl_r;
  reg [7:0] misc_r;
  reg [7:0] strap_r;
  reg ale_mode_r;
  reg ovl_strap_r;
  reg slow_strap_r;
  reg [23:0] lat_addr_r;
  reg rst_d_r;
  reg vret_d_r;
  reg seen_run_r;
  reg [1:0] mem_st_r;
  reg [2:0] wait_cnt_r;
  reg pclk_r;

  wire susp = ~susp_n_s;
  wire hold = rst_pin_s & ~susp;
  // Bus masked in suspend
  wire io_rd = ~ior_n_s & ~susp;
  wire io_wr = ~iow_n_s & ~susp;
  wire io_ok = ~io_decode_enable_n_n_s & ~susp;
  wire mem_rd = ~memr_n_s & ~susp & memory_decode_enable_s;
  wire mem_wr = ~memw_n_s & ~susp & memory_decode_enable_s;
  wire [23:0] addr_eff = ale_mode_r ?
    {lat_addr_r[`IHD_LAT_MSB:`IHD_LAT_LSB], addr_s[`IHD_LAT_LSB-1:0]} :
    addr_s;
  wire [2:0] sel = io_ok ? io_sel(addr_eff[15:0]) : `IHD_SEL_NONE;
  wire own_reg = (sel != `IHD_SEL_NONE) && (sel != `IHD_SEL_DAC);
  wire mem_hit = (addr_eff >= `IHD_MEM_LO) && (addr_eff <= `IHD_MEM_HI);
  wire mem_cyc = (mem_rd | mem_wr) & mem_hit;
  wire pd = susp | sw_power_save_i;

  reg [7:0] rd_byte;
  always @*
  begin
    case (sel)
      `IHD_SEL_SENSE: rd_byte = {5'h00, sense_s};
      `IHD_SEL_CTL: rd_byte = ctl_r;
      `IHD_SEL_STRAP: rd_byte = strap_r;
      `IHD_SEL_MISC: rd_byte = misc_r;
      default: rd_byte = 8'h00;
    endcase
  end

  // Registers, straps and address latch
  always @(posedge clk_sys_i or negedge reset_n_i)
  begin
    if (!reset_n_i)
    begin
      ctl_r <= `IHD_CTL_RST;
      misc_r <= `IHD_MISC_RST;
      strap_r <= `IHD_STRAP_RST;
      ale_mode_r <= 1'b0;
      ovl_strap_r <= 1'b0;
      slow_strap_r <= 1'b0;
      lat_addr_r <= 24'h00_0000;
      rst_d_r <= 1'b0;
    end
    else if (ce_i)
    begin
      rst_d_r <= hold;
      if (rst_d_r && !hold)
      begin
        // Captured once per reset release, then left alone
        strap_r <= {md_s[`IHD_STRAP_HI_MSB:`IHD_STRAP_HI_LSB],
          md_s[`IHD_STRAP_LO_MSB:`IHD_STRAP_LO_LSB]};
        ale_mode_r <= md_s[`IHD_STRAP_ALE];
        ovl_strap_r <= md_s[`IHD_STRAP_OVL];
        slow_strap_r <= md_s[`IHD_STRAP_SLOW];
      end
      if (hold)
      begin
        ctl_r <= `IHD_CTL_RST;
        misc_r <= `IHD_MISC_RST;
      end
      else if (io_wr && sel == `IHD_SEL_CTL)
        ctl_r <= data_s[7:0];
      else if (io_wr && sel == `IHD_SEL_MISC)
        misc_r <= data_s[7:0];
      if (ale_s && !susp)
        lat_addr_r <= addr_s;
    end
  end

  // Host bus answers and memory wait states
  always @(posedge clk_sys_i or negedge reset_n_i)
  begin
    if (!reset_n_i)
    begin
      isa_data_o <= 16'h0000;
      isa_data_oe_o <= 1'b0;
      isa_zws_n_o <= 1'b1;
      isa_zws_oe_o <= 1'b0;
      isa_ready_o <= 1'b1;
      isa_ready_oe_o <= 1'b0;
      dac_read_strobe_n_o <= 1'b1;
      dac_write_strobe_n_o <= 1'b1;
      mem_st_r <= ST_IDLE;
      wait_cnt_r <= 3'h0;
      host_addr_o <= 24'h00_0000;
      host_mem_req_o <= 1'b0;
      host_mem_write_o <= 1'b0;
      host_wdata_o <= 16'h0000;
      host_bhe_n_o <= 1'b1;
    end
    else if (ce_i)
    begin
      host_mem_req_o <= 1'b0;
      if (hold)
      begin
        isa_data_oe_o <= 1'b0;
        isa_zws_oe_o <= 1'b0;
        isa_ready_oe_o <= 1'b0;
        dac_read_strobe_n_o <= 1'b1;
        dac_write_strobe_n_o <= 1'b1;
        mem_st_r <= ST_IDLE;
      end
      else
      begin
        isa_data_oe_o <= (io_rd & own_reg) | (mem_rd & mem_hit);
        isa_data_o <= (mem_rd & mem_hit) ? host_mem_rdata_i : {8'h00, rd_byte};
        isa_zws_n_o <= 1'b0;
        isa_zws_oe_o <= (io_rd | io_wr) & (sel != `IHD_SEL_NONE);
        dac_read_strobe_n_o <= ~(io_rd & (sel == `IHD_SEL_DAC));
        dac_write_strobe_n_o <= ~(io_wr & (sel == `IHD_SEL_DAC));
        isa_ready_o <= 1'b0;
        case (mem_st_r)
          ST_IDLE:
            if (mem_cyc)
            begin
              mem_st_r <= ST_WAIT;
              wait_cnt_r <= `IHD_CNT_ONE;
              isa_ready_oe_o <= 1'b1;
              host_mem_req_o <= 1'b1;
              host_mem_write_o <= mem_wr;
              host_addr_o <= addr_eff;
              host_wdata_o <= data_s;
              host_bhe_n_o <= bhe_n_s;
            end
          ST_WAIT:
            if (wait_cnt_r == `IHD_MEM_WAIT_CYC)
            begin
              mem_st_r <= ST_DONE;
              isa_ready_oe_o <= 1'b0;
            end
            else
              wait_cnt_r <= wait_cnt_r + `IHD_CNT_ONE;
          ST_DONE:
            if (!mem_cyc)
              mem_st_r <= ST_IDLE;
          default:
            mem_st_r <= ST_IDLE;
        endcase
      end
    end
  end

  // Interrupt, power and strap-driven outputs
  always @(posedge clk_sys_i or negedge reset_n_i)
  begin
    if (!reset_n_i)
    begin
      isa_irq_o <= 1'b0;
      isa_irq_oe_o <= 1'b0;
      vret_d_r <= 1'b0;
      seen_run_r <= 1'b0;
      power_down_o <= 1'b0;
      internal_slow_clock_enable_o <= 1'b1;
      panel_power_enable_n_o <= 1'b1;
    end
    else if (ce_i)
    begin
      vret_d_r <= dtu_vretrace_i;
      power_down_o <= pd;
      internal_slow_clock_enable_o <= ~slow_strap_r;
      if (hold)
      begin
        isa_irq_o <= 1'b0;
        isa_irq_oe_o <= 1'b0;
        seen_run_r <= 1'b0;
        panel_power_enable_n_o <= 1'b1;
      end
      else
      begin
        // A new retrace edge beats a clear in the same cycle
        isa_irq_o <= (isa_irq_o & ~dtu_irq_clear_i) |
          (dtu_vretrace_i & ~vret_d_r & dtu_irq_enable_i);
        isa_irq_oe_o <= ~ctl_r[`IHD_CTL_IRQ_DIS];
        if (dtu_running_i)
          seen_run_r <= 1'b1;
        panel_power_enable_n_o <= ~(seen_run_r & dtu_running_i & ~pd &
          ~seq_reset_i);
      end
    end
  end

  // Pixel clock and DAC side outputs
  always @(posedge clk_sys_i or negedge reset_n_i)
  begin
    if (!reset_n_i)
    begin
      pclk_r <= 1'b0;
      dac_pixel_clock_o <= 1'b0;
      pixel_select_out_o <= 8'h00;
      dac_blank_n_o <= 1'b0;
      dac_hsync_o <= 1'b0;
      dac_vsync_o <= 1'b0;
      dac_register_select_hi_o <= 1'b0;
      dac_mode_control_o <= 1'b0;
      overlay_select_low_o <= 2'h0;
      overlay_select_low_oe_o <= 1'b0;
      overlay_select_upper_o <= 1'b0;
    end
    else if (ce_i)
    begin
      pclk_r <= ~pclk_r;
      dac_pixel_clock_o <= ~pclk_r;
      if (pclk_r)
        pixel_select_out_o <= hold ? 8'h00 : dtu_pixel_i;
      if (hold)
      begin
        dac_blank_n_o <= 1'b0;
        dac_hsync_o <= misc_r[`IHD_MISC_HPOL];
        dac_vsync_o <= misc_r[`IHD_MISC_VPOL];
        dac_register_select_hi_o <= 1'b0;
        dac_mode_control_o <= 1'b0;
        overlay_select_low_oe_o <= 1'b0;
        overlay_select_upper_o <= 1'b0;
      end
      else
      begin
        dac_blank_n_o <= ~dtu_blank_i;
        dac_hsync_o <= dtu_hsync_i ^ misc_r[`IHD_MISC_HPOL];
        dac_vsync_o <= dtu_vsync_i ^ misc_r[`IHD_MISC_VPOL];
        dac_register_select_hi_o <= ctl_r[`IHD_CTL_RS_HI];
        dac_mode_control_o <= ctl_r[`IHD_CTL_MODE] & ~pd;
        overlay_select_low_o <= cursor_overlay_i[1:0];
        overlay_select_low_oe_o <= ~ovl_strap_r;
        overlay_select_upper_o <= cursor_overlay_i[2];
      end
    end
  end

  // Panel pins, parked in suspend
  always @(posedge clk_sys_i or negedge reset_n_i)
  begin
    if (!reset_n_i)
    begin
      upper_panel_data_o <= 4'h0;
      lower_panel_data_o <= 4'h0;
      panel_shift_clock_o <= 1'b0;
      backplane_bias_o <= 1'b0;
      panel_oe_o <= 1'b0;
    end
    else if (ce_i)
    begin
      if (susp)
      begin
        upper_panel_data_o <= 4'h0;
        lower_panel_data_o <= 4'h0;
        panel_shift_clock_o <= 1'b0;
        backplane_bias_o <= 1'b0;
        panel_oe_o <= ~ctl_r[`IHD_CTL_PANEL_FLOAT];
      end
      else
      begin
        {upper_panel_data_o, lower_panel_data_o} <= hold ? 8'h00 : panel_data_i;
        panel_shift_clock_o <= panel_shift_clock_i & ~hold;
        backplane_bias_o <= backplane_bias_i & ~hold;
        panel_oe_o <= ~hold;
      end
    end
  end

endmodule // ihd_top

// ===== testbench/ihd_top_asserts.sv
// Concurrent checks on the host/DAC pin block ports
`timescale 1ns/1ns
module ihd_top_asserts (
  // Clock and reset
  input wire clk_sys_i,
  input wire reset_n_i,
  // Host pins
  input wire isa_ior_n_i,
  input wire isa_iow_n_i,
  input wire isa_memr_n_i,
  input wire hw_suspend_request_n_i,
  input wire isa_data_oe_o,
  input wire isa_zws_oe_o,
  input wire isa_ready_oe_o,
  input wire host_mem_req_o,
  input wire isa_irq_o,
  // Display timing side
  input wire dtu_vretrace_i,
  input wire dtu_irq_enable_i,
  input wire dtu_irq_clear_i,
  // DAC and panel pins
  input wire dac_read_strobe_n_o,
  input wire dac_write_strobe_n_o,
  input wire [7:0] pixel_select_out_o,
  input wire dac_pixel_clock_o,
  input wire panel_power_enable_n_o
);
  default clocking @(posedge clk_sys_i); endclocking
  default disable iff (!reset_n_i);
  // Last five samples of the suspend pin
  reg [4:0] susp_sh;
  always @(posedge clk_sys_i or negedge reset_n_i)
    if (!reset_n_i)
      susp_sh <= 5'h00;
    else
      susp_sh <= {susp_sh[3:0], ~hw_suspend_request_n_i};
  sequence s_wait_five;
    isa_ready_oe_o [*5] ##1 !isa_ready_oe_o;
  endsequence
  sequence s_irq_rise;
    $rose(dtu_vretrace_i) && dtu_irq_enable_i;
  endsequence
  AST_DATA_ONLY_READ: assert property (isa_data_oe_o |->
    !$past(isa_ior_n_i, 3) || !$past(isa_memr_n_i, 3)) else $error("data driven outside read");
  AST_ZWS_ONLY_IO: assert property (isa_zws_oe_o |->
    !$past(isa_ior_n_i, 3) || !$past(isa_iow_n_i, 3)) else $error("zero wait outside io");
  AST_READY_WAIT: assert property ($rose(isa_ready_oe_o) |-> s_wait_five)
    else $error("wait length wrong");
  AST_MEM_REQ_PULSE: assert property (host_mem_req_o |-> isa_ready_oe_o ##1 !host_mem_req_o)
    else $error("memory request without wait");
  AST_SUSP_MASK: assert property (&susp_sh |->
    !isa_data_oe_o && !isa_zws_oe_o && dac_read_strobe_n_o) else $error("bus live in suspend");
  AST_SUSP_PANEL: assert property (&susp_sh |-> panel_power_enable_n_o)
    else $error("panel power on in suspend");
  AST_IRQ_SET: assert property (s_irq_rise |=> isa_irq_o)
    else $error("interrupt not set");
  AST_IRQ_CLEAR: assert property (dtu_irq_clear_i && !($rose(dtu_vretrace_i) && dtu_irq_enable_i)
    |=> !isa_irq_o) else $error("interrupt not cleared");
  AST_PIXEL_FALL: assert property ($changed(pixel_select_out_o) |-> $fell(dac_pixel_clock_o))
    else $error("pixel changed off falling edge");
  AST_DAC_WR: assert property (!dac_write_strobe_n_o |-> !$past(isa_iow_n_i, 3))
    else $error("dac write strobe without write");
  AST_DAC_RD: assert property (!dac_read_strobe_n_o |-> !$past(isa_ior_n_i, 3))
    else $error("dac read strobe without read");
endmodule // ihd_top_asserts
bind ihd_top ihd_top_asserts ihd_top_asserts_inst (.*);

// ===== testbench/ihd_dac_model.sv
// Palette DAC and monitor cable model beyond the DAC pins
`timescale 1ns/1ns
module ihd_dac_model (
  // DAC pins
  input wire dac_pixel_clock_o,
  input wire [7:0] pixel_select_out_o,
  input wire dac_read_strobe_n_o,
  input wire dac_write_strobe_n_o,
  // Monitor cable
  input wire [2:0] sense_pull_low_i,
  output wire [2:0] monitor_sense_in_o,
  // Observations
  output logic [7:0] pixel_seen_o,
  output int rd_count_o,
  output int wr_count_o
);
  // Pulled-up lines read high unless grounded by the monitor
  assign monitor_sense_in_o = ~sense_pull_low_i;
  initial
  begin
    rd_count_o = 0;
    wr_count_o = 0;
    pixel_seen_o = 8'h00;
  end
  // Sampled mid-period, away from the launching fall
  always @(posedge dac_pixel_clock_o)
    pixel_seen_o <= pixel_select_out_o;
  always @(negedge dac_read_strobe_n_o)
    rd_count_o <= rd_count_o + 1;
  always @(negedge dac_write_strobe_n_o)
    wr_count_o <= wr_count_o + 1;
endmodule // ihd_dac_model

// ===== testbench/ihd_top_test.sv
// Self-checking bench for the host/DAC pin block
`timescale 1ns/1ns
`include "ihd_map.vh"
module ihd_top_test;
  localparam logic [15:0] A_SENSE = `IHD_AUX_BASE + `IHD_OFF_SENSE;
  localparam logic [15:0] A_CTL = `IHD_AUX_BASE + `IHD_OFF_CTL;
  localparam logic [15:0] A_STRAP = `IHD_AUX_BASE + `IHD_OFF_STRAP;
  logic clk_sys_i = 1'h0, reset_n_i = 1'h0, ce_i = 1'h1, isa_ale_i = 1'h0;
  logic [23:0] isa_addr_i = 24'h00_0000;
  logic [15:0] isa_data_i = 16'h0000, memory_data_pins_i = 16'h0000, host_mem_rdata_i = 16'h0000;
  logic isa_ior_n_i = 1'h1, isa_iow_n_i = 1'h1, isa_memr_n_i = 1'h1, isa_memw_n_i = 1'h1;
  logic isa_bhe_n_i = 1'h1, memory_decode_enable_i = 1'h1, io_decode_enable_n_i = 1'h0;
  logic isa_reset_i = 1'h0, hw_suspend_request_n_i = 1'h1, dtu_blank_i = 1'h0;
  logic dtu_hsync_i = 1'h0, dtu_vsync_i = 1'h0, dtu_vretrace_i = 1'h0, dtu_irq_enable_i = 1'h0;
  logic dtu_irq_clear_i = 1'h0, dtu_running_i = 1'h0, seq_reset_i = 1'h0, sw_power_save_i = 1'h0;
  logic panel_shift_clock_i = 1'h0, backplane_bias_i = 1'h0;
  logic [7:0] dtu_pixel_i = 8'h00, panel_data_i = 8'h00;
  logic [2:0] cursor_overlay_i = 3'h0, sense_pull = 3'h0;
  logic scramble = 1'h0;
  logic [7:0] cv [4] = '{8'h00, 8'h08, 8'h10, 8'h18};
  logic [15:0] md [2] = '{16'h1e25, 16'h6a3a};
  wire [2:0] monitor_sense_in_i;
  wire [15:0] isa_data_o, host_wdata_o;
  wire [23:0] host_addr_o;
  wire [7:0] pixel_select_out_o, pix_seen;
  wire [3:0] upper_panel_data_o, lower_panel_data_o;
  wire [1:0] overlay_select_low_o;
  wire isa_data_oe_o, isa_ready_o, isa_ready_oe_o, isa_irq_o, isa_irq_oe_o, isa_zws_n_o;
  wire isa_zws_oe_o, power_down_o, internal_slow_clock_enable_o, host_mem_req_o;
  wire host_mem_write_o, host_bhe_n_o, dac_pixel_clock_o, dac_blank_n_o, dac_hsync_o;
  wire dac_vsync_o, dac_read_strobe_n_o, dac_write_strobe_n_o, dac_register_select_hi_o;
  wire dac_mode_control_o, overlay_select_low_oe_o, overlay_select_upper_o;
  wire panel_shift_clock_o, backplane_bias_o, panel_oe_o, panel_power_enable_n_o;
  int bad_count = 0, checks_done = 0, rd_cnt, wr_cnt, n, k;

  ihd_top ihd_top_inst (.*);
  ihd_dac_model ihd_dac_model_inst (.dac_pixel_clock_o, .pixel_select_out_o,
    .dac_read_strobe_n_o, .dac_write_strobe_n_o, .sense_pull_low_i(sense_pull),
    .monitor_sense_in_o(monitor_sense_in_i), .pixel_seen_o(pix_seen),
    .rd_count_o(rd_cnt), .wr_count_o(wr_cnt));

  always #10 clk_sys_i = ~clk_sys_i;

  task automatic stop_test;
    $display("checks %0d mismatches %0d", checks_done, bad_count);
    if (bad_count == 0 && checks_done > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask
  task automatic chk(input string what, input logic [23:0] seen, input logic [23:0] exp);
    checks_done++;
    if (seen !== exp)
    begin
      bad_count++;
      $display("ERROR %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic tick(input int c);
    repeat (c) @(posedge clk_sys_i);
    #2;
  endtask
  // ALE pulse, then one I/O strobe held five cycles; a read checks the answer
  task automatic io(input logic wr, input logic [15:0] a, input logic [7:0] d,
    input logic [7:0] exp, input logic oe);
    isa_addr_i = {8'h00, a};
    isa_data_i = {8'h00, d};
    isa_ale_i = 1'h1;
    tick(1);
    isa_ale_i = 1'h0;
    // Garbled after ALE, so only a latched address still decodes
    if (scramble)
      isa_addr_i[15:2] = ~a[15:2];
    isa_iow_n_i = ~wr;
    isa_ior_n_i = wr;
    tick(5);
    if (!wr)
    begin
      chk("data_oe", isa_data_oe_o, oe);
      if (oe)
      begin
        chk("rdata", isa_data_o, {8'h00, exp});
        chk("zws_oe", isa_zws_oe_o, 1'h1);
        chk("zws_lvl", isa_zws_n_o, 1'h0);
      end
    end
    isa_iow_n_i = 1'h1;
    isa_ior_n_i = 1'h1;
    tick(5);
  endtask
  // Memory strobe of twelve cycles, counting requests and wait cycles
  task automatic mem(input logic wr, input logic en);
    memory_decode_enable_i = en;
    isa_addr_i = 24'h0a_1234;
    isa_data_i = 16'hbeef;
    host_mem_rdata_i = 16'h5a3c;
    isa_bhe_n_i = 1'h0;
    isa_memw_n_i = ~wr;
    isa_memr_n_i = wr;
    n = 0;
    k = 0;
    repeat (12)
    begin
      @(posedge clk_sys_i);
      #1;
      n += host_mem_req_o;
      k += isa_ready_oe_o;
    end
    #1;
    chk("mem_req", 24'(n), 24'(en));
    chk("wait_cycles", 24'(k), 24'(5 * en));
    if (en)
    begin
      chk("maddr", host_addr_o, 24'h0a_1234);
      chk("mwrite", host_mem_write_o, wr);
      chk("mbhe", host_bhe_n_o, 1'h0);
      chk("ready_lvl", isa_ready_o, 1'h0);
      chk("mdata", wr ? host_wdata_o : isa_data_o, wr ? 16'hbeef : 16'h5a3c);
    end
    isa_memw_n_i = 1'h1;
    isa_memr_n_i = 1'h1;
    isa_bhe_n_i = 1'h1;
    memory_decode_enable_i = 1'h1;
    tick(5);
  endtask

  initial
  begin
    #200000;
    bad_count++;
    stop_test();
  end

  initial
  begin
    tick(6);
    reset_n_i = 1'h1;
    tick(3);
    chk("pwr_n", panel_power_enable_n_o, 1'h1);
    io(0, A_CTL, 0, `IHD_CTL_RST, 1);
    io(0, `IHD_MISC_ADDR, 0, `IHD_MISC_RST, 1);
    sense_pull = 3'h5;
    io(1, A_SENSE, 8'hff, 0, 0);
    io(0, A_SENSE, 0, 8'h02, 1);
    io(0, 16'h02d9, 0, 0, 0);
    foreach (cv[i])
    begin
      io(1, A_CTL, cv[i], 0, 0);
      io(0, A_CTL, 0, cv[i], 1);
      chk("rs_hi", dac_register_select_hi_o, cv[i][3]);
      chk("dac_mode", dac_mode_control_o, cv[i][4]);
    end
    sw_power_save_i = 1'h1;
    tick(4);
    chk("dac_mode_ps", dac_mode_control_o, 1'h0);
    chk("pdown", power_down_o, 1'h1);
    sw_power_save_i = 1'h0;
    for (int m = 0; m < 4; m++)
    begin
      io(1, `IHD_MISC_ADDR, {m[1:0], 6'h00}, 0, 0);
      dtu_hsync_i = 1'h1;
      dtu_vsync_i = m[0];
      dtu_blank_i = m[1];
      tick(3);
      chk("hsync", dac_hsync_o, !m[0]);
      chk("vsync", dac_vsync_o, m[0] ^ m[1]);
      chk("blank_n", dac_blank_n_o, !m[1]);
    end
    // Clock enable low freezes the outputs
    ce_i = 1'h0;
    dtu_blank_i = 1'h0;
    tick(3);
    chk("ce_hold", dac_blank_n_o, 1'h0);
    ce_i = 1'h1;
    tick(2);
    chk("ce_run", dac_blank_n_o, 1'h1);
    io(1, `IHD_DAC_LO, 8'h11, 0, 0);
    io(0, `IHD_DAC_HI, 0, 0, 0);
    chk("dac_wr", 24'(wr_cnt), 24'h00_0001);
    chk("dac_rd", 24'(rd_cnt), 24'h00_0001);
    io_decode_enable_n_i = 1'h1;
    io(1, `IHD_DAC_LO, 8'h22, 0, 0);
    io(0, A_CTL, 0, 0, 0);
    chk("dac_wr_off", 24'(wr_cnt), 24'h00_0001);
    io_decode_enable_n_i = 1'h0;
    mem(0, 1);
    mem(1, 1);
    mem(0, 0);
    dtu_irq_enable_i = 1'h1;
    dtu_vretrace_i = 1'h1;
    tick(2);
    chk("irq_set", {isa_irq_o, isa_irq_oe_o}, 2'h3);
    dtu_vretrace_i = 1'h0;
    dtu_irq_clear_i = 1'h1;
    tick(1);
    dtu_irq_clear_i = 1'h0;
    tick(1);
    chk("irq_clr", isa_irq_o, 1'h0);
    dtu_irq_enable_i = 1'h0;
    dtu_vretrace_i = 1'h1;
    tick(2);
    chk("irq_off", isa_irq_o, 1'h0);
    dtu_vretrace_i = 1'h0;
    io(1, A_CTL, 8'h80, 0, 0);
    chk("irq_float", isa_irq_oe_o, 1'h0);
    dtu_pixel_i = 8'ha5;
    cursor_overlay_i = 3'h5;
    tick(6);
    chk("pixel", pix_seen, 8'ha5);
    chk("ovl", {overlay_select_low_oe_o, overlay_select_upper_o, overlay_select_low_o}, 4'hd);
    dtu_running_i = 1'h1;
    panel_data_i = 8'h3c;
    panel_shift_clock_i = 1'h1;
    backplane_bias_i = 1'h1;
    tick(4);
    chk("pwr_run", panel_power_enable_n_o, 1'h0);
    chk("panel", {panel_shift_clock_o, backplane_bias_o, upper_panel_data_o,
      lower_panel_data_o}, 10'h33c);
    seq_reset_i = 1'h1;
    tick(4);
    chk("pwr_seq", panel_power_enable_n_o, 1'h1);
    seq_reset_i = 1'h0;
    io(1, A_CTL, 8'h18, 0, 0);
    hw_suspend_request_n_i = 1'h0;
    tick(5);
    chk("susp_pd", power_down_o, 1'h1);
    chk("susp_pwr", panel_power_enable_n_o, 1'h1);
    chk("susp_panel", {panel_oe_o, panel_shift_clock_o, backplane_bias_o, upper_panel_data_o,
      lower_panel_data_o}, 11'h400);
    io(1, A_CTL, 8'h00, 0, 0);
    io(0, A_CTL, 0, 0, 0);
    isa_reset_i = 1'h1;
    tick(4);
    isa_reset_i = 1'h0;
    hw_suspend_request_n_i = 1'h1;
    tick(4);
    io(0, A_CTL, 0, 8'h18, 1);
    // Plain ISA timing: a garbled address after ALE must miss
    scramble = 1'h1;
    io(0, A_CTL, 0, 0, 0);
    foreach (md[i])
    begin
      memory_data_pins_i = md[i];
      isa_reset_i = 1'h1;
      tick(4);
      isa_reset_i = 1'h0;
      tick(4);
      memory_data_pins_i = ~md[i];
      tick(3);
      io(0, A_STRAP, 0, {md[i][12:9], md[i][3:0]}, 1);
      io(0, A_CTL, 0, 8'h00, 1);
      chk("slow_en", internal_slow_clock_enable_o, !md[i][14]);
      chk("ovl_oe", overlay_select_low_oe_o, !md[i][13]);
    end
    stop_test();
  end
endmodule // ihd_top_test
